// file: shared/dtc_params.svh
// Purpose: constants of the termination control block
// Assumes: 10 MHz sys_clk, word-indexed register bus
// Notes: offsets, mode and timing field positions and cycle counts live here; the status word layout is packed in the control block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_PERIOD_PS 100000
`define DTC_ASYNC_MIN_PS 2000
`define DTC_ASYNC_MAX_PS 8500
`define DTC_ASYNC_MIN_CYC ((`DTC_ASYNC_MIN_PS + `DTC_PERIOD_PS - 1) / `DTC_PERIOD_PS)
`define DTC_ASYNC_MAX_CYC (((`DTC_ASYNC_MAX_PS / `DTC_PERIOD_PS) < 1) ? 1 : (`DTC_ASYNC_MAX_PS / `DTC_PERIOD_PS))
`define DTC_LAT_OFFSET 6'h02
`define DTC_CHOP_HOLD 7'h04
`define DTC_FULL_HOLD 7'h06
`define DTC_SKEW_CYC 8'h01
`define DTC_MOD_CYC 8'h0C
`define DTC_CAL_REF_OHM 240
`define DTC_IDX_MODE_ONE 2'h0
`define DTC_IDX_MODE_TWO 2'h1
`define DTC_IDX_TIMING 2'h2
`define DTC_IDX_STATUS 2'h3
`define DTC_NOM_B9 9
`define DTC_NOM_B6 6
`define DTC_NOM_B2 2
`define DTC_WR_B9 9
`define DTC_WR_B10 10
`define DTC_CWL_LSB 0
`define DTC_AL_LSB 8
`define DTC_MODE_ONE_RST 32'h00000000
`define DTC_MODE_TWO_RST 32'h00000000
`define DTC_TIMING_RST 32'h00000005
`define DTC_DIV_OFF 4'h0
`define DTC_DIV_2 4'h2
`define DTC_DIV_4 4'h4
`define DTC_DIV_6 4'h6
`define DTC_DIV_8 4'h8
`define DTC_DIV_12 4'hC
`endif

// file: shared/dtc_pkg.sv
// Purpose: types of the termination control block
// Assumes: nothing beyond the params header
// Notes: codes match the mode register field encodings
package dtc_pkg;
  typedef enum logic [2:0] {
    DTC_NOM_OFF = 3'b000,
    DTC_NOM_DIV4 = 3'b001,
    DTC_NOM_DIV2 = 3'b010,
    DTC_NOM_DIV6 = 3'b011,
    DTC_NOM_DIV12 = 3'b100,
    DTC_NOM_DIV8 = 3'b101,
    DTC_NOM_RSV6 = 3'b110,
    DTC_NOM_RSV7 = 3'b111
  } dtc_nom_t;
  typedef enum logic [1:0] {
    DTC_WR_OFF = 2'b00,
    DTC_WR_DIV4 = 2'b01,
    DTC_WR_DIV2 = 2'b10,
    DTC_WR_RSV = 2'b11
  } dtc_wr_t;
  typedef enum logic [0:0] {
    DTC_ST_NOMINAL = 1'b0,
    DTC_ST_WRITE = 1'b1
  } dtc_str_t;
endpackage

// file: hw/dtc_delay_line.sv
// Purpose: tapped one-bit delay line for latency counts
// Assumes: tap below or equal to DEPTH
// Notes: tap 0 passes din through combinationally
`timescale 1ns/1ps
module dtc_delay_line
  import dtc_pkg::*;
#(
  parameter int DEPTH = 72,
  parameter int TW = 7
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic din,
  input wire logic [TW-1:0] tap,
  output logic dout
);
  logic [DEPTH-1:0] sr_q;
  logic [DEPTH-1:0] sr_d;

  // shift one place per clock
  always_comb begin
    sr_d = {sr_q[DEPTH-2:0], din};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sr_q <= '0;
    end else begin
      sr_q <= sr_d;
    end
  end

  // out-of-range taps read low rather than wrapping
  always_comb begin
    if (tap == '0) begin
      dout = din;
    end else if (int'(tap) > DEPTH) begin
      dout = 1'b0;
    end else begin
      dout = sr_q[tap - TW'(1)];
    end
  end
endmodule

// file: hw/dtc_regs.sv
// Purpose: Avalon-MM slave holding the mode and timing images
// Assumes: master holds request until waitrequest low
// Notes: every access takes two cycles
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_regs
  import dtc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] status_word,
  output logic [31:0] mode_one_q,
  output logic [31:0] mode_two_q,
  output logic [31:0] timing_q,
  output logic mode_one_load_q
);
  logic [31:0] mode_one_d, mode_two_d, timing_d, rdata_d;
  logic wait_d, load_d, take;

  // first cycle of a request loads read data, second completes it
  always_comb begin
    take = (avs_read | avs_write) & ~avs_waitrequest;
    wait_d = ~((avs_read | avs_write) & avs_waitrequest);
    mode_one_d = mode_one_q;
    mode_two_d = mode_two_q;
    timing_d = timing_q;
    load_d = 1'b0;
    rdata_d = avs_readdata;
    if (avs_read & avs_waitrequest) begin
      unique case (avs_address)
        `DTC_IDX_MODE_ONE: rdata_d = mode_one_q;
        `DTC_IDX_MODE_TWO: rdata_d = mode_two_q;
        `DTC_IDX_TIMING: rdata_d = timing_q;
        `DTC_IDX_STATUS: rdata_d = status_word;
      endcase
    end
    if (take & avs_write) begin
      unique case (avs_address)
        `DTC_IDX_MODE_ONE: begin
          mode_one_d = avs_writedata;
          load_d = 1'b1;
        end
        `DTC_IDX_MODE_TWO: mode_two_d = avs_writedata;
        `DTC_IDX_TIMING: timing_d = avs_writedata;
        `DTC_IDX_STATUS: load_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_one_q <= `DTC_MODE_ONE_RST;
      mode_two_q <= `DTC_MODE_TWO_RST;
      timing_q <= `DTC_TIMING_RST;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      mode_one_load_q <= 1'b0;
    end else begin
      mode_one_q <= mode_one_d;
      mode_two_q <= mode_two_d;
      timing_q <= timing_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= wait_d;
      mode_one_load_q <= load_d;
    end
  end

  wait_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low longer than one cycle");
  req_answer_a: assert property (@(posedge sys_clk) disable iff (reset)
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("request not answered");
endmodule

// file: hw/dtc_term_ctrl.sv
// Purpose: on-die termination control of a synchronous dram
// Assumes: write commands and state flags come from logic on sys_clk
// Notes: the termination pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "dtc_params.svh"
module dtc_term_ctrl
  import dtc_pkg::*;
#(
  parameter int DEPTH = 72,
  parameter int TW = 7
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic termination_control_pin,
  input wire logic write_cmd,
  input wire logic write_burst_chop_four,
  input wire logic self_refresh,
  input wire logic async_mode,
  output logic term_on_q,
  output logic [3:0] term_divider_q,
  output logic term_undefined_q,
  output logic term_uncertain_q
);
  logic [31:0] mode_one_q, mode_two_q, timing_q, status_word;
  logic mode_one_load_q;
  logic pin_meta_q, pin_s_q, pin_meta_d, pin_s_d;
  dtc_nom_t nom_code;
  dtc_wr_t wr_code;
  logic nom_en, nom_illegal, dyn_en, wr_illegal;
  logic [3:0] nom_div, wr_div;
  logic [4:0] write_cas_latency, al;
  logic [5:0] lat;
  logic [TW-1:0] tap_on, tap_start, tap_chop, tap_full;
  logic pin_eff, req_dly, term_req;
  logic start_dly, end_chop_dly, end_full_dly;
  dtc_str_t str_q, str_d;
  logic term_on_d, undef_d;
  logic [3:0] div_d;
  logic [7:0] unc_cnt_q, unc_cnt_d;
  logic win_active;

  // register file over the bus
  dtc_regs u_regs (
    .sys_clk(sys_clk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .status_word(status_word),
    .mode_one_q(mode_one_q),
    .mode_two_q(mode_two_q),
    .timing_q(timing_q),
    .mode_one_load_q(mode_one_load_q)
  );

  always_comb begin
    pin_meta_d = termination_control_pin;
    pin_s_d = pin_meta_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_meta_q <= 1'b0;
      pin_s_q <= 1'b0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_s_q <= pin_s_d;
    end
  end

  // nominal field gathered from bits 9, 6, 2
  always_comb begin
    nom_code = dtc_nom_t'({mode_one_q[`DTC_NOM_B9], mode_one_q[`DTC_NOM_B6], mode_one_q[`DTC_NOM_B2]});
    wr_code = dtc_wr_t'({mode_two_q[`DTC_WR_B10], mode_two_q[`DTC_WR_B9]});
  end

  // nominal strength decode, reserved codes disable
  always_comb begin
    nom_en = 1'b1;
    nom_illegal = 1'b0;
    nom_div = `DTC_DIV_OFF;
    unique case (nom_code)
      DTC_NOM_OFF: nom_en = 1'b0;
      DTC_NOM_DIV4: nom_div = `DTC_DIV_4;
      DTC_NOM_DIV2: nom_div = `DTC_DIV_2;
      DTC_NOM_DIV6: nom_div = `DTC_DIV_6;
      DTC_NOM_DIV12: nom_div = `DTC_DIV_12;
      DTC_NOM_DIV8: nom_div = `DTC_DIV_8;
      DTC_NOM_RSV6, DTC_NOM_RSV7: begin
        nom_en = 1'b0;
        nom_illegal = 1'b1;
      end
    endcase
  end

  // write strength decode; reserved code kept off so no strength is guessed
  always_comb begin
    wr_div = `DTC_DIV_OFF;
    wr_illegal = 1'b0;
    unique case (wr_code)
      DTC_WR_OFF: wr_div = `DTC_DIV_OFF;
      DTC_WR_DIV4: wr_div = `DTC_DIV_4;
      DTC_WR_DIV2: wr_div = `DTC_DIV_2;
      DTC_WR_RSV: wr_illegal = 1'b1;
    endcase
  end

  // exactly one write bit set enables dynamic switching
  always_comb begin
    dyn_en = (mode_two_q[`DTC_WR_B9] | mode_two_q[`DTC_WR_B10]) & ~wr_illegal;
  end

  // shared latency cwl plus al minus two, clamped to one
  always_comb begin
    write_cas_latency = timing_q[`DTC_CWL_LSB +: 5];
    al = timing_q[`DTC_AL_LSB +: 5];
    lat = {1'b0, write_cas_latency} + {1'b0, al};
    if (lat > `DTC_LAT_OFFSET) begin
      lat = lat - `DTC_LAT_OFFSET;
    end else begin
      lat = 6'h01;
    end
    tap_on = {1'b0, lat} - 7'h01;
    // write_cmd enters its delay line two flops earlier than the synchronised pin,
    // so the write taps are one longer to land lat clocks after the write edge
    tap_start = {1'b0, lat};
    // back to nominal four or six plus turn-off latency
    tap_chop = {1'b0, lat} + `DTC_CHOP_HOLD;
    tap_full = {1'b0, lat} + `DTC_FULL_HOLD;
  end

  // pin ignored in self refresh or with both strengths off
  always_comb begin
    pin_eff = pin_s_q & ~self_refresh & (nom_en | dyn_en);
  end

  // pin request delayed by the on/off latency
  dtc_delay_line #(.DEPTH(DEPTH), .TW(TW)) u_pin_dly (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(pin_eff),
    .tap(tap_on),
    .dout(req_dly)
  );

  // write start reaches the switch after wl minus two
  dtc_delay_line #(.DEPTH(DEPTH), .TW(TW)) u_wr_start (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(write_cmd & dyn_en),
    .tap(tap_start),
    .dout(start_dly)
  );

  // chopped write end marker
  dtc_delay_line #(.DEPTH(DEPTH), .TW(TW)) u_wr_end_chop (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(write_cmd & dyn_en & write_burst_chop_four),
    .tap(tap_chop),
    .dout(end_chop_dly)
  );

  // full-length write end marker
  dtc_delay_line #(.DEPTH(DEPTH), .TW(TW)) u_wr_end_full (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(write_cmd & dyn_en & ~write_burst_chop_four),
    .tap(tap_full),
    .dout(end_full_dly)
  );

  // asynchronous mode bypasses all latency, including al
  // one cycle at 10 MHz is the closest this clock gets to the analog delay
  always_comb begin
    term_req = async_mode ? pin_eff : req_dly;
  end

  // strength window state; a new start beats a coinciding end
  always_comb begin
    str_d = str_q;
    unique case (str_q)
      DTC_ST_NOMINAL: begin
        if (start_dly) begin
          str_d = DTC_ST_WRITE;
        end
      end
      DTC_ST_WRITE: begin
        if (start_dly) begin
          str_d = DTC_ST_WRITE;
        end else if (end_chop_dly | end_full_dly) begin
          str_d = DTC_ST_NOMINAL;
        end
      end
    endcase
    if (~dyn_en | async_mode) begin
      str_d = DTC_ST_NOMINAL;
    end
  end

  // with nominal off, termination only inside the write window
  always_comb begin
    win_active = (str_d == DTC_ST_WRITE) & dyn_en;
    term_on_d = term_req & ~self_refresh & (nom_en | win_active);
    if (~term_on_d) begin
      div_d = `DTC_DIV_OFF;
    end else if (win_active) begin
      div_d = wr_div;
    end else begin
      div_d = nom_div;
    end
    // flag one cycle of undefined strength at each switch that ends with termination on
    undef_d = (str_d != str_q) & term_on_d;
  end

  always_comb begin
    unc_cnt_d = unc_cnt_q;
    if (mode_one_load_q) begin
      unc_cnt_d = {2'b00, lat} + `DTC_SKEW_CYC + `DTC_MOD_CYC + 8'h01;
    end else if (unc_cnt_q != 8'h00) begin
      unc_cnt_d = unc_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      str_q <= DTC_ST_NOMINAL;
      term_on_q <= 1'b0;
      term_divider_q <= `DTC_DIV_OFF;
      term_undefined_q <= 1'b0;
      unc_cnt_q <= 8'h00;
      term_uncertain_q <= 1'b0;
    end else begin
      str_q <= str_d;
      term_on_q <= term_on_d;
      term_divider_q <= div_d;
      term_undefined_q <= undef_d;
      unc_cnt_q <= unc_cnt_d;
      term_uncertain_q <= (unc_cnt_d != 8'h00);
    end
  end

  // status view for software
  always_comb begin
    status_word = {22'h000000, wr_illegal, nom_illegal, term_uncertain_q, term_undefined_q,
                   (str_q == DTC_ST_WRITE), term_on_q, term_divider_q};
  end

  // helper: length of the write window in cycles
  logic [7:0] win_len_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      win_len_q <= 8'h00;
    end else if (str_q == DTC_ST_WRITE) begin
      win_len_q <= win_len_q + 8'h01;
    end else begin
      win_len_q <= 8'h00;
    end
  end

  // assertions watch registered outputs, decoded mode state, str_q, start_dly, pin_s_q and the self_refresh and async_mode inputs
  self_refresh_off_a: assert property (@(posedge sys_clk) disable iff (reset)
    self_refresh |=> !term_on_q) else $error("termination on in self refresh");
  both_disabled_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!nom_en && !dyn_en) |=> !term_on_q) else $error("termination on with both strengths off");
  async_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
    (async_mode && !self_refresh && (nom_en | dyn_en)) |-> ##1 (term_on_q == $past(pin_s_q && nom_en)))
    else $error("asynchronous termination did not follow pin");
  legal_div_a: assert property (@(posedge sys_clk) disable iff (reset)
    term_on_q |-> term_divider_q inside {`DTC_DIV_2, `DTC_DIV_4, `DTC_DIV_6, `DTC_DIV_8, `DTC_DIV_12})
    else $error("illegal strength while on");
  off_zero_div_a: assert property (@(posedge sys_clk) disable iff (reset)
    !term_on_q |-> term_divider_q == `DTC_DIV_OFF) else $error("strength shown while off");
  skew_one_cycle_a: assert property (@(posedge sys_clk) disable iff (reset)
    term_undefined_q |=> !term_undefined_q) else $error("skew flag too long");
  skew_at_switch_a: assert property (@(posedge sys_clk) disable iff (reset)
    term_undefined_q |-> $changed(str_q)) else $error("skew flag without strength change");
  write_window_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(str_q == DTC_ST_WRITE) && dyn_en && !async_mode |-> win_len_q >= 8'h04)
    else $error("write window shorter than four cycles");
  uncertain_load_a: assert property (@(posedge sys_clk) disable iff (reset)
    mode_one_load_q |=> term_uncertain_q [*8]) else $error("uncertainty not held after load");
  nominal_only_window_a: assert property (@(posedge sys_clk) disable iff (reset)
    (!nom_en && str_q == DTC_ST_NOMINAL && !start_dly) |=> !term_on_q)
    else $error("termination outside write window with nominal off");
  write_strength_a: assert property (@(posedge sys_clk) disable iff (reset)
    term_on_q && str_q == DTC_ST_WRITE && dyn_en |-> term_divider_q == wr_div)
    else $error("write strength not applied in window");
endmodule

// file: testbench/dtc_ctrl_model.sv
// Purpose: controller side that drives the termination pin and write commands
// Assumes: the bench changes its requests just after a rising edge
// Notes: minimum high times are enforced here, so the bench may ask for any level
`timescale 1ns/1ps
module dtc_ctrl_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic want_hi,
  input wire logic wr_go,
  input wire logic wr_chop,
  output logic termination_control_pin = 1'b0,
  output logic write_cmd = 1'b0,
  output logic write_burst_chop_four = 1'b0
);
  int hold = 0;
  int gap = 0;
  logic hi;
  // one decision per edge; writes spaced so windows never pile up
  always @(posedge sys_clk) begin
    hold = (hold > 0) ? hold - 1 : 0;
    gap = (gap > 0) ? gap - 1 : 0;
    // four high clocks after a rise, low in reset
    hi = !reset && (want_hi || hold > 0);
    if (hi && !termination_control_pin) begin
      hold = 4;
    end
    write_cmd <= !reset && wr_go && gap == 0;
    if (!reset && wr_go && gap == 0) begin
      gap = 8;
      write_burst_chop_four <= wr_chop;
      if (hi && hold < (wr_chop ? 4 : 6)) begin
        hold = wr_chop ? 4 : 6;
      end
    end
    termination_control_pin <= hi;
  end
endmodule

// file: testbench/tb.sv
// Purpose: self-checking bench of the termination control block
// Assumes: the controller model keeps the minimum pin high times
// Notes: a cycle model built on pin and write history predicts term_on_q, term_divider_q and term_undefined_q
`timescale 1ns/1ps
module tb;
  import dtc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'h5D87;
  logic avs_waitrequest, pin, wcmd, wchop, want_hi = 1'b0, wr_go = 1'b0, wr_chop = 1'b0;
  logic self_refresh = 1'b0, async_mode = 1'b0, term_on_q, term_undefined_q, term_uncertain_q, chk = 1'b0;
  logic [3:0] term_divider_q;
  int miscompares = 0, total_checks = 0, cyc = 0, nom = 0, wr = 0, lat = 3, n, unc = 0;
  bit p [16384];
  bit w [16384];
  bit c [16384];
  always #50 sys_clk = ~sys_clk;
  dtc_term_ctrl dut_u (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .termination_control_pin(pin), .write_cmd(wcmd),
    .write_burst_chop_four(wchop), .self_refresh(self_refresh), .async_mode(async_mode), .term_on_q(term_on_q),
    .term_divider_q(term_divider_q), .term_undefined_q(term_undefined_q), .term_uncertain_q(term_uncertain_q));
  dtc_ctrl_model ctl_u (.sys_clk(sys_clk), .reset(reset), .want_hi(want_hi), .wr_go(wr_go), .wr_chop(wr_chop),
    .termination_control_pin(pin), .write_cmd(wcmd), .write_burst_chop_four(wchop));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] ndiv(int code);
    logic [3:0] t [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8, 4'h0, 4'h0};
    return t[code];
  endfunction
  // a write counts while its strength window is open
  function automatic bit win_at(int k);
    for (int j = k - lat - 5; j <= k - lat; j++) begin
      if (j >= 0 && w[j] && k < j + lat + (c[j] ? 4 : 6)) return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr_n, input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr_n;
    avs_write <= wr_n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      test_done();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  // history of what the block registered at each edge
  always @(posedge sys_clk) begin
    cyc++;
    p[cyc] = pin;
    w[cyc] = wcmd && (wr == 1 || wr == 2) && !async_mode;
    c[cyc] = wchop;
    if (term_uncertain_q === 1'b1) unc++;
  end
  // compare the cycle model with the outputs once they have settled
  always @(negedge sys_clk) begin
    bit ne, we, on, wi;
    if (chk) begin
      ne = nom >= 1 && nom <= 5;
      we = wr == 1 || wr == 2;
      wi = win_at(cyc);
      on = (ne || we) && !self_refresh && (async_mode ? p[cyc - 2] : p[cyc - 1 - lat]) && (ne || wi);
      check("term_on_q", term_on_q, on);
      if (on) check("term_divider_q", term_divider_q, (we && wi) ? (wr == 1 ? 4'h4 : 4'h2) : ndiv(nom));
      if (on && ne && we) check("term_undefined_q", term_undefined_q, wi != win_at(cyc - 1));
    end
  end
  // pin low while the mode images change, then image readback and uncertainty length
  task automatic setup(input int nm, input int wm, input int write_cas_latency, input int al, input bit am);
    chk = 1'b0;
    want_hi <= 1'b0;
    wr_go <= 1'b0;
    async_mode <= am;
    repeat (30) @(posedge sys_clk);
    lat = (write_cas_latency + al - 2 < 1) ? 1 : write_cas_latency + al - 2;
    bus(1'b1, 2'h2, {19'h0, al[4:0], 3'h0, write_cas_latency[4:0]});
    bus(1'b1, 2'h1, {21'h0, wm[1], wm[0], 9'h0});
    wr = wm;
    unc = 0;
    bus(1'b1, 2'h0, {22'h0, nm[2], 2'h0, nm[1], 3'h0, nm[0], 2'h0});
    nom = nm;
    bus(1'b0, 2'h0, 32'h0);
    check("mode_reg_one", rd, {22'h0, nm[2], 2'h0, nm[1], 3'h0, nm[0], 2'h0});
    repeat (40) @(posedge sys_clk);
    check("uncertain cycles", unc, lat + 14);
    chk = 1'b1;
  endtask
  // random pin levels and writes from the xorshift source
  task automatic traffic(input int cycles, input bit tie, input bit wok);
    repeat (cycles) begin
      void'(xs());
      want_hi <= tie | seed[0] | seed[1];
      wr_go <= wok && seed[4:2] == 3'h0;
      wr_chop <= seed[5];
      @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, i[1:0], 32'h0);
      check("reset image", rd, (i == 2) ? 32'h00000005 : 32'h00000000);
    end
    setup(2, 0, 5, 0, 0);
    traffic(150, 0, 1);
    setup(1, 1, 6, 3, 0);
    traffic(200, 0, 1);
    setup(3, 2, 5, 0, 0);
    traffic(200, 0, 1);
    setup(4, 0, 2, 0, 0);
    traffic(150, 0, 0);
    setup(5, 0, 5, 0, 1);
    traffic(150, 0, 0);
    setup(0, 1, 5, 0, 0);
    traffic(200, 1, 1);
    setup(2, 1, 5, 0, 0);
    traffic(100, 1, 1);
    setup(6, 3, 5, 0, 0);
    traffic(100, 0, 1);
    setup(0, 0, 5, 0, 0);
    traffic(100, 0, 1);
    setup(2, 0, 5, 0, 0);
    want_hi <= 1'b1;
    repeat (20) @(posedge sys_clk);
    bus(1'b0, 2'h3, 32'h0);
    check("status", rd[4:0], 5'h12);
    want_hi <= 1'b0;
    repeat (10) @(posedge sys_clk);
    self_refresh <= 1'b1;
    repeat (5) @(posedge sys_clk);
    want_hi <= 1'b1;
    repeat (20) @(posedge sys_clk);
    want_hi <= 1'b0;
    repeat (10) @(posedge sys_clk);
    test_done();
  end
endmodule
